// >>> logic/mailbox_defs.vh
// Contract
// - One empty/full flag per byte of each four-byte mailbox.
// - Writing an outgoing mailbox byte sets its flag in both status registers.
// - Receiving side reading a full byte clears its flag in both registers.
// - Status registers are read-only; writes never change flags.
// - Writing 1 to either flag-reset bit clears all flags; 0 does nothing.
// - Host status: 31:28 full incoming bytes, 15:12 unread outgoing bytes.
// - Local status: 15:12 full incoming bytes, 31:28 unread outgoing bytes.
// - Writing a full outgoing byte overwrites it; never refused.
// - Host control bit 4 enables outgoing interrupt, bits 1:0 pick byte.
// - Host control bit 12 enables incoming interrupt, bits 9:8 pick byte.
// - Local control bit 12 enables outgoing interrupt, bits 9:8 pick byte.
// - Local control bit 4 enables incoming interrupt, bits 1:0 pick byte.
// - Host control: bit 23 irq asserted, 17 incoming pending, 16 outgoing.
// - Local control: bit 23 irq asserted, 17 outgoing pending, 16 incoming.
// - Host writing 1 to bit 17 or 16 clears that pending request.
// - Local writing 1 to bit 17 or 16 clears that pending request.
// - Incoming interrupt cannot clear while the selected byte stays full.
// - Outgoing interrupt rises only when the other side's read empties the byte.
// - Both enables and selects of one side set in one write.
// - Interrupt asserts on second clock edge after the triggering access.
// - Host interrupt deasserts one cycle after its pending request clears.
// - Local interrupt deasserts one cycle after its pending request clears.
`ifndef MAILBOX_DEFS_VH
`define MAILBOX_DEFS_VH

// ----------------------------------------------------------------
// Register offsets, byte address bits 6:2
// ----------------------------------------------------------------
`define MB_OFS_INCOMING   5'h00
`define MB_OFS_OUTGOING   5'h01
`define MB_OFS_FLAGS      5'h02
`define MB_OFS_INT_CTRL   5'h03
`define MB_OFS_RESET_CTRL 5'h04

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MB_FLAG_HI_LSB    28
`define MB_FLAG_LO_LSB    12
`define MB_IC_SEL_A_LSB   0
`define MB_IC_EN_A_BIT    4
`define MB_IC_SEL_B_LSB   8
`define MB_IC_EN_B_BIT    12
`define MB_IC_PEND0_BIT   16
`define MB_IC_PEND1_BIT   17
`define MB_IC_ASSERT_BIT  23
`define MB_RC_FLAG_RST    27

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MB_RST_WORD       32'h0000_0000
`define MB_RST_FLAGS      4'h0
`define MB_RST_SEL        2'h0

`endif

// >>> logic/sync_2ff.v
`timescale 1ns/1ps
module sync_2ff #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         sys_rst_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;

    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end
        else
        begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end

    assign q_o = s2_q;
endmodule

// >>> logic/mailbox_core.v
`timescale 1ns/1ps
`include "mailbox_defs.vh"
module mailbox_core (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    // Host register port, core clock
    input  wire        host_sel_i,
    input  wire        host_wr_i,
    input  wire        host_rd_i,
    input  wire [6:2]  host_addr_i,
    input  wire [3:0]  host_be_i,
    input  wire [31:0] host_wdata_i,
    output wire [31:0] host_rdata_o,
    output wire        host_rvalid_o,
    output wire        host_irq_n_o,
    // Local bus pins, local clock domain
    input  wire        local_clk_i,
    input  wire        local_sel_n_i,
    input  wire        local_rd_n_i,
    input  wire        local_wr_n_i,
    input  wire [6:2]  local_adr_i,
    input  wire [3:0]  local_be_n_i,
    input  wire [31:0] local_dq_i,
    output wire [31:0] local_dq_o,
    output wire        local_dq_oe_o,
    output wire        local_irq_n_o
);
    // ----------------------------------------------------------------
    // Local pin synchronisers
    // ----------------------------------------------------------------
    wire [44:0] l_raw;
    wire [44:0] l_syn;
    reg         l_clk_prev_q;

    assign l_raw = {local_clk_i, local_sel_n_i, local_rd_n_i, local_wr_n_i,
                    local_adr_i, local_be_n_i, local_dq_i};

    sync_2ff #(
        .W (45)
    ) u_lsync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (l_raw),
        .q_o       (l_syn)
    );

    wire        l_clk_s  = l_syn[44];
    wire        l_rise   = l_clk_s & ~l_clk_prev_q;
    wire        l_sel    = ~l_syn[43];
    wire        l_rd     = ~l_syn[42];
    wire        l_wr     = ~l_syn[41];
    wire [4:0]  l_adr    = l_syn[40:36];
    wire [3:0]  l_be     = ~l_syn[35:32];
    wire [31:0] l_dq     = l_syn[31:0];

    // Local strobes, one core cycle per local rising edge
    wire l_rd_ev = l_rise & l_sel & l_rd;
    wire l_wr_ev = l_rise & l_sel & l_wr;

    wire h_rd_ev = host_sel_i & host_rd_i;
    wire h_wr_ev = host_sel_i & host_wr_i;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg  [31:0] host_out_mbox_q;
    reg  [31:0] local_out_mbox_q;
    reg  [3:0]  host_out_full_q;
    reg  [3:0]  local_out_full_q;
    reg  [3:0]  host_out_full_d;
    reg  [3:0]  local_out_full_d;
    reg         hi_en_out_q;
    reg  [1:0]  hi_sel_out_q;
    reg         hi_en_in_q;
    reg  [1:0]  hi_sel_in_q;
    reg         li_en_in_q;
    reg  [1:0]  li_sel_in_q;
    reg         li_en_out_q;
    reg  [1:0]  li_sel_out_q;
    reg         h_pend_in_q;
    reg         h_pend_out_q;
    reg         l_pend_in_q;
    reg         l_pend_out_q;
    reg         host_irq_q;
    reg         local_irq_q;
    reg  [31:0] host_rdata_q;
    reg         host_rvalid_q;
    reg  [31:0] local_dq_q;
    reg         local_dq_oe_q;
    reg  [31:0] host_rdata_d;
    reg  [31:0] local_rdata_d;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire h_wr_out = h_wr_ev & (host_addr_i == `MB_OFS_OUTGOING);
    wire h_rd_in  = h_rd_ev & (host_addr_i == `MB_OFS_INCOMING);
    wire h_wr_ic  = h_wr_ev & (host_addr_i == `MB_OFS_INT_CTRL);
    wire h_wr_rc  = h_wr_ev & (host_addr_i == `MB_OFS_RESET_CTRL);
    wire l_wr_out = l_wr_ev & (l_adr == `MB_OFS_OUTGOING);
    wire l_rd_in  = l_rd_ev & (l_adr == `MB_OFS_INCOMING);
    wire l_wr_ic  = l_wr_ev & (l_adr == `MB_OFS_INT_CTRL);
    wire l_wr_rc  = l_wr_ev & (l_adr == `MB_OFS_RESET_CTRL);

    // Byte events per side
    wire [3:0] h_set = h_wr_out ? host_be_i : 4'h0;
    wire [3:0] l_set = l_wr_out ? l_be : 4'h0;
    wire [3:0] l_clr = l_rd_in ? l_be : 4'h0;
    wire [3:0] h_clr = h_rd_in ? host_be_i : 4'h0;

    wire flag_rst = (h_wr_rc & host_be_i[3] & host_wdata_i[`MB_RC_FLAG_RST]) |
                    (l_wr_rc & l_be[3] & l_dq[`MB_RC_FLAG_RST]);

    // ----------------------------------------------------------------
    // Mailbox data, byte lanes
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_lane
            always @(posedge clk_i)
            begin
                if (sys_rst_i)
                begin
                    host_out_mbox_q[gi*8 +: 8]  <= 8'h00;
                    local_out_mbox_q[gi*8 +: 8] <= 8'h00;
                end
                else
                begin
                    if (h_set[gi])
                        host_out_mbox_q[gi*8 +: 8] <= host_wdata_i[gi*8 +: 8];
                    if (l_set[gi])
                        local_out_mbox_q[gi*8 +: 8] <= l_dq[gi*8 +: 8];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Byte flags, set wins over any clear
    // ----------------------------------------------------------------
    always @*
    begin
        host_out_full_d  = (host_out_full_q & ~l_clr & ~{4{flag_rst}}) | h_set;
        local_out_full_d = (local_out_full_q & ~h_clr & ~{4{flag_rst}}) | l_set;
    end

    // ----------------------------------------------------------------
    // Interrupt events
    // ----------------------------------------------------------------
    wire h_in_set  = hi_en_in_q & l_set[hi_sel_in_q];
    wire h_out_set = hi_en_out_q & l_clr[hi_sel_out_q] &
                     host_out_full_q[hi_sel_out_q] & ~h_set[hi_sel_out_q];
    wire l_in_set  = li_en_in_q & h_set[li_sel_in_q];
    wire l_out_set = li_en_out_q & h_clr[li_sel_out_q] &
                     local_out_full_q[li_sel_out_q] & ~l_set[li_sel_out_q];

    wire h_in_clr  = h_wr_ic & host_be_i[2] & host_wdata_i[`MB_IC_PEND1_BIT] &
                     ~local_out_full_q[hi_sel_in_q];
    wire h_out_clr = h_wr_ic & host_be_i[2] & host_wdata_i[`MB_IC_PEND0_BIT];
    wire l_out_clr = l_wr_ic & l_be[2] & l_dq[`MB_IC_PEND1_BIT];
    wire l_in_clr  = l_wr_ic & l_be[2] & l_dq[`MB_IC_PEND0_BIT] &
                     ~host_out_full_q[li_sel_in_q];

    // ----------------------------------------------------------------
    // Sequential state
    // ----------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            l_clk_prev_q     <= 1'b0;
            host_out_full_q  <= `MB_RST_FLAGS;
            local_out_full_q <= `MB_RST_FLAGS;
            hi_en_out_q      <= 1'b0;
            hi_sel_out_q     <= `MB_RST_SEL;
            hi_en_in_q       <= 1'b0;
            hi_sel_in_q      <= `MB_RST_SEL;
            li_en_in_q       <= 1'b0;
            li_sel_in_q      <= `MB_RST_SEL;
            li_en_out_q      <= 1'b0;
            li_sel_out_q     <= `MB_RST_SEL;
            h_pend_in_q      <= 1'b0;
            h_pend_out_q     <= 1'b0;
            l_pend_in_q      <= 1'b0;
            l_pend_out_q     <= 1'b0;
            host_irq_q       <= 1'b0;
            local_irq_q      <= 1'b0;
        end
        else
        begin
            l_clk_prev_q     <= l_clk_s;
            host_out_full_q  <= host_out_full_d;
            local_out_full_q <= local_out_full_d;
            if (h_wr_ic & host_be_i[0])
            begin
                hi_en_out_q  <= host_wdata_i[`MB_IC_EN_A_BIT];
                hi_sel_out_q <= host_wdata_i[`MB_IC_SEL_A_LSB +: 2];
            end
            if (h_wr_ic & host_be_i[1])
            begin
                hi_en_in_q   <= host_wdata_i[`MB_IC_EN_B_BIT];
                hi_sel_in_q  <= host_wdata_i[`MB_IC_SEL_B_LSB +: 2];
            end
            if (l_wr_ic & l_be[0])
            begin
                li_en_in_q   <= l_dq[`MB_IC_EN_A_BIT];
                li_sel_in_q  <= l_dq[`MB_IC_SEL_A_LSB +: 2];
            end
            if (l_wr_ic & l_be[1])
            begin
                li_en_out_q  <= l_dq[`MB_IC_EN_B_BIT];
                li_sel_out_q <= l_dq[`MB_IC_SEL_B_LSB +: 2];
            end
            h_pend_in_q  <= h_in_set | (h_pend_in_q & ~h_in_clr);
            h_pend_out_q <= h_out_set | (h_pend_out_q & ~h_out_clr);
            l_pend_in_q  <= l_in_set | (l_pend_in_q & ~l_in_clr);
            l_pend_out_q <= l_out_set | (l_pend_out_q & ~l_out_clr);
            host_irq_q   <= h_pend_in_q | h_pend_out_q;
            local_irq_q  <= l_pend_in_q | l_pend_out_q;
        end
    end

    // ----------------------------------------------------------------
    // Read views
    // ----------------------------------------------------------------
    wire [31:0] flags_word = ({28'h000_0000, local_out_full_q} << `MB_FLAG_HI_LSB) |
                             ({28'h000_0000, host_out_full_q} << `MB_FLAG_LO_LSB);

    wire [31:0] host_ic_word = {8'h00, host_irq_q, 5'h00, h_pend_in_q, h_pend_out_q,
                                3'h0, hi_en_in_q, 2'h0, hi_sel_in_q,
                                3'h0, hi_en_out_q, 2'h0, hi_sel_out_q};

    wire [31:0] local_ic_word = {8'h00, local_irq_q, 5'h00, l_pend_out_q, l_pend_in_q,
                                 3'h0, li_en_out_q, 2'h0, li_sel_out_q,
                                 3'h0, li_en_in_q, 2'h0, li_sel_in_q};

    always @*
    begin
        case (host_addr_i)
            `MB_OFS_INCOMING: host_rdata_d = local_out_mbox_q;
            `MB_OFS_OUTGOING: host_rdata_d = host_out_mbox_q;
            `MB_OFS_FLAGS:    host_rdata_d = flags_word;
            `MB_OFS_INT_CTRL: host_rdata_d = host_ic_word;
            default:          host_rdata_d = `MB_RST_WORD;
        endcase
        case (l_adr)
            `MB_OFS_INCOMING: local_rdata_d = host_out_mbox_q;
            `MB_OFS_OUTGOING: local_rdata_d = local_out_mbox_q;
            `MB_OFS_FLAGS:    local_rdata_d = flags_word;
            `MB_OFS_INT_CTRL: local_rdata_d = local_ic_word;
            default:          local_rdata_d = `MB_RST_WORD;
        endcase
    end

    // ----------------------------------------------------------------
    // Read data registers
    // ----------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            host_rdata_q  <= `MB_RST_WORD;
            host_rvalid_q <= 1'b0;
            local_dq_q    <= `MB_RST_WORD;
            local_dq_oe_q <= 1'b0;
        end
        else
        begin
            host_rvalid_q <= h_rd_ev;
            if (h_rd_ev)
                host_rdata_q <= host_rdata_d;
            if (l_rise)
            begin
                local_dq_oe_q <= l_sel & l_rd;
                if (l_sel & l_rd)
                    local_dq_q <= local_rdata_d;
            end
        end
    end

    assign host_rdata_o  = host_rdata_q;
    assign host_rvalid_o = host_rvalid_q;
    assign host_irq_n_o  = ~host_irq_q;
    assign local_irq_n_o = ~local_irq_q;
    assign local_dq_o    = local_dq_q;
    assign local_dq_oe_o = local_dq_oe_q;
endmodule

// >>> verification/mailbox_core_chk.sv
`timescale 1ns/1ps
module mailbox_core_chk (
    input logic        clk_i,
    input logic        sys_rst_i,
    input logic        host_sel_i,
    input logic        host_wr_i,
    input logic        host_rd_i,
    input logic [6:2]  host_addr_i,
    input logic [3:0]  host_be_i,
    input logic [31:0] host_rdata_o,
    input logic        host_rvalid_o,
    input logic        host_irq_n_o,
    input logic        local_sel_n_i,
    input logic        local_rd_n_i,
    input logic        local_wr_n_i,
    input logic [6:2]  local_adr_i,
    input logic        local_dq_oe_o,
    input logic        local_irq_n_o
);
    // ------------------------------
    // Cycles since the last control write on each side and the last local read
    // ------------------------------
    logic [3:0] hc_age_q;
    logic [3:0] lc_age_q;
    logic [3:0] lr_age_q;
    logic       lsel;
    assign lsel = !local_sel_n_i;
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            hc_age_q <= 4'hf;
            lc_age_q <= 4'hf;
            lr_age_q <= 4'hf;
        end
        else
        begin
            hc_age_q <= (host_sel_i && host_wr_i && host_addr_i == 5'h03 && host_be_i[2]) ?
                        4'h0 : hc_age_q + {3'h0, hc_age_q != 4'hf};
            lc_age_q <= (lsel && !local_wr_n_i && local_adr_i == 5'h03) ?
                        4'h0 : lc_age_q + {3'h0, lc_age_q != 4'hf};
            lr_age_q <= (lsel && !local_rd_n_i) ? 4'h0 : lr_age_q + {3'h0, lr_age_q != 4'hf};
        end
    end
    // ------------------------------
    // Assertions
    // ------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_out_wr;
        host_sel_i && host_wr_i && host_addr_i == 5'h01;
    endsequence
    sequence s_flag_rd;
        host_sel_i && host_rd_i && host_addr_i == 5'h02;
    endsequence
    a_rvalid_after_read: assert property (host_sel_i && host_rd_i |=> host_rvalid_o)
        else $error("read not answered");
    a_rvalid_only_read: assert property (!(host_sel_i && host_rd_i) |=> !host_rvalid_o)
        else $error("stray read valid");
    a_reset_idle: assert property (disable iff (1'b0) $past(sys_rst_i) |->
        host_irq_n_o && local_irq_n_o && !local_dq_oe_o && !host_rvalid_o)
        else $error("outputs not idle in reset");
    a_out_flag_set: assert property (s_out_wr ##2 s_flag_rd |=>
        (host_rdata_o[15:12] & $past(host_be_i, 3)) == $past(host_be_i, 3))
        else $error("outgoing flag not set");
    a_unmapped_zero: assert property (host_sel_i && host_rd_i && host_addr_i >= 5'h04 |=>
        host_rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
    a_host_irq_clear: assert property ($rose(host_irq_n_o) |-> hc_age_q < 4'h4)
        else $error("host irq released without clear");
    a_ctrl_irq_bit: assert property (host_sel_i && host_rd_i && host_addr_i == 5'h03 |=>
        host_rdata_o[23] == !$past(host_irq_n_o)) else $error("irq bit mismatch");
    a_local_irq_clear: assert property ($rose(local_irq_n_o) |-> lc_age_q < 4'hc)
        else $error("local irq released without clear");
    a_dq_oe_read: assert property ($rose(local_dq_oe_o) |-> lr_age_q < 4'hc)
        else $error("data driven without read");
endmodule

bind mailbox_core mailbox_core_chk u_chk (.*);

// >>> verification/local_bus_model.sv
`timescale 1ns/1ps
module local_bus_model (
    output reg        lclk_o,
    output reg        sel_n_o,
    output reg        rd_n_o,
    output reg        wr_n_o,
    output reg [6:2]  adr_o,
    output reg [3:0]  be_n_o,
    output reg [31:0] dq_o,
    input  wire [31:0] dq_i,
    input  wire        dq_oe_i
);
    initial
    begin
        {sel_n_o, rd_n_o, wr_n_o, adr_o, be_n_o, dq_o} = {3'h7, 5'h00, 4'hf, 32'h0000_0000};
        lclk_o = 1'b0;
        forever #24 lclk_o = ~lclk_o;
    end
    // One access, pins held a full local cycle around the sampling edge
    task acc(input w, input [4:0] a, input [3:0] bn, input [31:0] wd, output [31:0] rd);
    begin
        @(negedge lclk_o);
        {sel_n_o, rd_n_o, wr_n_o, adr_o, be_n_o} = {1'b0, w, !w, a, bn};
        dq_o = w ? wd : ~dq_o;
        @(negedge lclk_o);
        {sel_n_o, rd_n_o, wr_n_o} = 3'h7;
        dq_o = ~dq_o;
        @(posedge lclk_o);
        #4;
        rd = dq_oe_i ? dq_i : ~dq_i;
    end
    endtask
endmodule

// >>> verification/dual_port_mailbox_status_irq_tb.sv
`timescale 1ns/1ps
`define CHK(n,e,a) begin checks++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module dual_port_mailbox_status_irq_tb;
    logic clk_i, sys_rst_i, host_sel_i, host_wr_i, host_rd_i, host_irq_n_o, host_rvalid_o;
    logic [6:2] host_addr_i, local_adr_i;
    logic [3:0] host_be_i, local_be_n_i;
    logic [31:0] host_wdata_i, host_rdata_o, local_dq_i, local_dq_o, rd;
    logic local_clk_i, local_sel_n_i, local_rd_n_i, local_wr_n_i, local_dq_oe_o, local_irq_n_o;
    int checks, n_fail;
    mailbox_core uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_sel_i(host_sel_i),
        .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_addr_i(host_addr_i),
        .host_be_i(host_be_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
        .host_rvalid_o(host_rvalid_o), .host_irq_n_o(host_irq_n_o), .local_clk_i(local_clk_i),
        .local_sel_n_i(local_sel_n_i), .local_rd_n_i(local_rd_n_i), .local_wr_n_i(local_wr_n_i),
        .local_adr_i(local_adr_i), .local_be_n_i(local_be_n_i), .local_dq_i(local_dq_i),
        .local_dq_o(local_dq_o), .local_dq_oe_o(local_dq_oe_o), .local_irq_n_o(local_irq_n_o));
    local_bus_model m (.lclk_o(local_clk_i), .sel_n_o(local_sel_n_i), .rd_n_o(local_rd_n_i),
        .wr_n_o(local_wr_n_i), .adr_o(local_adr_i), .be_n_o(local_be_n_i), .dq_o(local_dq_i),
        .dq_i(local_dq_o), .dq_oe_i(local_dq_oe_o));
    // ------------------------------
    // Access tasks
    // ------------------------------
    task hacc(input w, input [4:0] a, input [3:0] b, input [31:0] d);
    begin
        @(posedge clk_i);
        #1;
        {host_sel_i, host_wr_i, host_rd_i} = {1'b1, w, !w};
        {host_addr_i, host_be_i, host_wdata_i} = {a, b, d};
        @(posedge clk_i);
        #1;
        {host_sel_i, host_wr_i, host_rd_i} = 3'h0;
        // Read data is registered, it stands from the next edge on
        if (!w)
        begin
            @(posedge clk_i);
            #1;
            rd = host_rdata_o;
        end
    end
    endtask
    task hw(input [4:0] a, input [3:0] b, input [31:0] d);
        hacc(1'b1, a, b, d);
    endtask
    task hc(input [4:0] a, input [3:0] b, input [31:0] e);
        logic [31:0] k;
    begin
        hacc(1'b0, a, b, 32'h0000_0000);
        k = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        `CHK("host read", e & k, rd & k)
    end
    endtask
    task lw(input [4:0] a, input [3:0] bn, input [31:0] d);
        m.acc(1'b1, a, bn, d, rd);
    endtask
    task lc(input [4:0] a, input [3:0] bn, input [31:0] e);
        logic [31:0] k;
    begin
        m.acc(1'b0, a, bn, 32'h0000_0000, rd);
        k = ~{{8{bn[3]}}, {8{bn[2]}}, {8{bn[1]}}, {8{bn[0]}}};
        `CHK("local read", e & k, rd & k)
    end
    endtask
    task wt(input bit w, input bit lv);
        int i;
    begin
        for (i = 0; i < 60 && (w ? local_irq_n_o : host_irq_n_o) !== lv; i++)
            @(posedge clk_i);
        `CHK("irq line", lv, w ? local_irq_n_o : host_irq_n_o)
    end
    endtask
    task wrap_up;
    begin
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    // ------------------------------
    // Clock and watchdog
    // ------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        wrap_up;
    end
    // ------------------------------
    // Scenarios
    // ------------------------------
    initial
    begin
        {sys_rst_i, host_sel_i, host_wr_i, host_rd_i, host_addr_i, host_be_i} = {4'h8, 9'h000};
        host_wdata_i = 32'h0000_0000;
        repeat (8) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        hc(5'h02, 4'hf, 32'h0000_0000);
        hc(5'h03, 4'hf, 32'h0000_0000);
        hc(5'h1f, 4'hf, 32'h0000_0000);
        hw(5'h01, 4'hf, 32'h4433_2211);
        hc(5'h02, 4'hf, 32'h0000_f000);
        lc(5'h02, 4'h0, 32'h0000_f000);
        hw(5'h02, 4'hf, 32'h0000_0000);
        hc(5'h02, 4'hf, 32'h0000_f000);
        lc(5'h00, 4'he, 32'h0000_0011);
        hc(5'h02, 4'hf, 32'h0000_e000);
        hw(5'h01, 4'h2, 32'h0000_5500);
        lc(5'h00, 4'hd, 32'h0000_5500);
        hw(5'h03, 4'h1, 32'h0000_0012);
        lc(5'h00, 4'hb, 32'h0033_0000);
        wt(1'b0, 1'b0);
        hc(5'h03, 4'h4, 32'h0081_0000);
        hw(5'h03, 4'h4, 32'h0001_0000);
        wt(1'b0, 1'b1);
        lw(5'h03, 4'he, 32'h0000_0011);
        hw(5'h01, 4'h2, 32'h0000_7700);
        wt(1'b1, 1'b0);
        lc(5'h03, 4'hb, 32'h0081_0000);
        lw(5'h03, 4'hb, 32'h0001_0000);
        repeat (10) @(posedge clk_i);
        `CHK("local irq held", 1'b0, local_irq_n_o)
        lc(5'h00, 4'hd, 32'h0000_7700);
        lw(5'h03, 4'hb, 32'h0001_0000);
        wt(1'b1, 1'b1);
        hw(5'h04, 4'h8, 32'h0000_0000);
        hc(5'h02, 4'hf, 32'h0000_8000);
        lw(5'h04, 4'h7, 32'h0800_0000);
        hc(5'h02, 4'hf, 32'h0000_0000);
        hw(5'h03, 4'h3, 32'h0000_1300);
        lw(5'h03, 4'hc, 32'h0000_1300);
        lc(5'h02, 4'h0, 32'h0000_0000);
        lw(5'h01, 4'h7, 32'hab00_0000);
        wt(1'b0, 1'b0);
        lc(5'h02, 4'h0, 32'h8000_0000);
        hc(5'h03, 4'h4, 32'h0082_0000);
        hw(5'h03, 4'h4, 32'h0002_0000);
        repeat (10) @(posedge clk_i);
        `CHK("host irq held", 1'b0, host_irq_n_o)
        hc(5'h00, 4'h8, 32'hab00_0000);
        wt(1'b1, 1'b0);
        lc(5'h03, 4'hb, 32'h0082_0000);
        hw(5'h03, 4'h4, 32'h0002_0000);
        wt(1'b0, 1'b1);
        lw(5'h03, 4'hb, 32'h0002_0000);
        wt(1'b1, 1'b1);
        wrap_up;
    end
endmodule
